// file: src/sfl_pkg.sv
/*
 * Constants, types and carriers for the switch frame and lookup
 * configuration block.
 * Assumes a byte-wide management port on the switch core clock.
 */
package sfl_pkg;

  // ********************************************
  // sizes
  // ********************************************
  localparam int LEN_W     = 14;
  localparam int TAG_W     = 16;
  localparam int IDX_W     = 10;
  localparam int MAC_W     = 48;
  localparam int AGE_W     = 3;
  localparam int HDR_BYTES = 14;

  // ********************************************
  // register byte addresses
  // ********************************************
  localparam logic [15:0] ADDR_SW_OP     = 16'h0300;
  localparam logic [15:0] ADDR_MAXLEN_HI = 16'h0308;
  localparam logic [15:0] ADDR_MAXLEN_LO = 16'h0309;
  localparam logic [15:0] ADDR_TAG_HI    = 16'h030A;
  localparam logic [15:0] ADDR_TAG_LO    = 16'h030B;
  localparam logic [15:0] ADDR_LK0       = 16'h0310;

  // ********************************************
  // field positions and reset values
  // ********************************************
  localparam int SWOP_DTAG_BIT  = 7;
  localparam int LK0_VLAN_BIT   = 7;
  localparam int LK0_DROP_BIT   = 6;
  localparam int LK0_AGE_LSB    = 3;
  localparam int LK0_RSVD_MC_BIT = 2;
  localparam int LK0_IDX_LSB    = 0;

  localparam logic [LEN_W-1:0] MAXLEN_RST   = 14'h07D0;
  localparam logic [LEN_W-1:0] MAXLEN_JUMBO = 14'h2328;
  localparam logic [1:0]       SPARE_HI_RST = 2'h0;
  localparam logic [TAG_W-1:0] TAG_RST      = 16'h9100;
  localparam logic             DTAG_RST     = 1'h0;
  localparam logic             VLAN_RST     = 1'h0;
  localparam logic             DROP_RST     = 1'h1;
  localparam logic [AGE_W-1:0] AGE_RST      = 3'h4;
  localparam logic             RSVD_MC_RST  = 1'h0;
  localparam logic [IDX_W-1:0] CRC_POLY     = 10'h233;

  // ********************************************
  // enumerations
  // ********************************************
  typedef enum logic [1:0] {
    IDX_DIRECT     = 2'h0,
    IDX_CRC        = 2'h1,
    IDX_XOR        = 2'h2,
    IDX_DIRECT_ALT = 2'h3
  } sfl_idx_type;

  typedef enum logic [1:0] {
    ACT_FWD     = 2'h0,
    ACT_DROP    = 2'h1,
    ACT_HOST    = 2'h2,
    ACT_UNK_VID = 2'h3
  } sfl_act_type;

  typedef enum logic [2:0] {
    TR_IDLE = 3'h1,
    TR_PASS = 3'h2,
    TR_CUT  = 3'h4
  } sfl_trunc_state_type;

  // ********************************************
  // carriers
  // ********************************************
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } sfl_mgmt_req_type;

  typedef struct packed {
    logic       valid;
    logic       sop;
    logic       eop;
    logic [7:0] data;
  } sfl_beat_type;

  typedef struct packed {
    logic valid;
    logic untagged;
    logic vid_invalid;
    logic unk_fwd_en;
  } sfl_cls_req_type;

  typedef struct packed {
    logic             valid;
    sfl_act_type      action;
    logic [TAG_W-1:0] inner_tpid;
    logic             push_outer;
    logic [TAG_W-1:0] outer_tpid;
  } sfl_cls_res_type;

  typedef struct packed {
    logic             valid;
    logic [MAC_W-1:0] mac;
  } sfl_lkp_req_type;

  typedef struct packed {
    logic             valid;
    logic [IDX_W-1:0] index;
  } sfl_lkp_res_type;

endpackage

// file: src/sfl_frame_trunc.sv
/*
 * Byte stream truncator: cuts frames whose payload passes the limit.
 * Assumes one byte per valid beat, sop and eop framing, no stall.
 */
`timescale 1ns/1ps
module sfl_frame_trunc #(
  parameter int LEN_W     = sfl_pkg::LEN_W,
  parameter int HDR_BYTES = sfl_pkg::HDR_BYTES
) (
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire logic [LEN_W-1:0]     max_len,
  input  wire sfl_pkg::sfl_beat_type in_beat,
  output sfl_pkg::sfl_beat_type     out_beat,
  output logic                      trunc_pulse
);

  localparam int CNT_W = LEN_W + 2;

  sfl_pkg::sfl_trunc_state_type state_reg;
  sfl_pkg::sfl_trunc_state_type state_next;
  logic [CNT_W-1:0]             cnt_reg;
  logic [CNT_W-1:0]             cnt_next;
  logic [CNT_W-1:0]             pos;
  logic [CNT_W-1:0]             limit;
  sfl_pkg::sfl_beat_type        out_reg;
  sfl_pkg::sfl_beat_type        out_next;
  logic                         trunc_reg;
  logic                         trunc_next;

  // ********************************************
  // byte counting and cut
  // ********************************************
  always_comb
  begin
    limit      = CNT_W'(HDR_BYTES) + CNT_W'(max_len);
    pos        = in_beat.sop ? CNT_W'(1) : cnt_reg + CNT_W'(1);
    state_next = state_reg;
    cnt_next   = cnt_reg;
    out_next   = '0;
    trunc_next = 1'h0;
    if (in_beat.valid)
    begin
      if (in_beat.sop || state_reg == sfl_pkg::TR_PASS)
      begin
        out_next = in_beat;
        cnt_next = pos;
        if (in_beat.eop)
          state_next = sfl_pkg::TR_IDLE;
        else if (pos >= limit)
        begin
          // last kept byte closes the frame, rest discarded
          out_next.eop = 1'h1;                           // RULE_02
          trunc_next   = 1'h1;                           // RULE_02
          state_next   = sfl_pkg::TR_CUT;                // RULE_02
        end
        else
          state_next = sfl_pkg::TR_PASS;
      end
      else if (state_reg == sfl_pkg::TR_CUT && in_beat.eop)
        state_next = sfl_pkg::TR_IDLE;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state_reg <= sfl_pkg::TR_IDLE;
      cnt_reg   <= '0;
      out_reg   <= '0;
      trunc_reg <= 1'h0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      out_reg   <= out_next;
      trunc_reg <= trunc_next;
    end
  end

  assign out_beat    = out_reg;
  assign trunc_pulse = trunc_reg;

  // ********************************************
  // checks
  // ********************************************
  a_trunc_closes: assert property (@(posedge clk) disable iff (!nrst) // RULE_02
    trunc_pulse |-> out_beat.valid && out_beat.eop)
    else $error("truncation without closing byte");

  a_trunc_discard: assert property (@(posedge clk) disable iff (!nrst) // RULE_02
    state_reg == sfl_pkg::TR_CUT && !in_beat.sop |=> !out_beat.valid)
    else $error("byte forwarded past payload limit");

endmodule // sfl_frame_trunc

// file: src/sfl_cfg_top.sv
/*
 * Frame length, default tag type and lookup engine configuration,
 * with the per-frame decisions that these settings steer.
 * Assumes the management port and frame stream on the core clock.
 */
`timescale 1ns/1ps
// Operation
// RULE_01 - 14-bit payload limit, bits 13:0 of 16-bit register, reset 0x07D0.
// RULE_02 - frames with payload beyond the limit are cut, excess discarded.
// RULE_03 - limit takes values up to 9000; software sets it for jumbo.
// RULE_04 - 16-bit tag type, reset 0x9100, given to untagged frames.
// RULE_05 - with double tagging on, tag type is the outer tag type.
// RULE_06 - bit 7 of lookup control zero enables VLAN mode, reset 0; the code enables it with bit 7 set.
// RULE_07 - software fills the VLAN table before enabling VLAN mode.
// RULE_08 - bit 6 set, reset 1: frames with invalid VLAN ID dropped.
// RULE_09 - bit 6 clear: invalid VLAN ID frames go to host port only.
// RULE_10 - unknown VLAN forwarding, when enabled, overrides bit 6.
// RULE_11 - bits 5:3 are age count, read/write, reset binary 100.
// RULE_12 - each dynamic entry update loads current age count.
// RULE_13 - bit 2 enables reserved multicast table lookup, reset 0.
// RULE_14 - index method 00 or 11: ten low destination address bits.
// RULE_15 - index method 01 (reset) CRC hash, 10 XOR hash.
// RULE_16 - double tagging only while switch operation bit 7 is set.
// RULE_17 - age count writes leave already stored entry ages unchanged.
module sfl_cfg_top (
  input  wire logic                    clk,
  input  wire logic                    nrst,
  input  wire sfl_pkg::sfl_mgmt_req_type mgmt_req,
  output logic [7:0]                   mgmt_rdata,
  output logic                         mgmt_rvalid,
  input  wire sfl_pkg::sfl_beat_type   frame_in,
  output sfl_pkg::sfl_beat_type        frame_out,
  output logic                         frame_trunc,
  input  wire sfl_pkg::sfl_cls_req_type cls_req,
  output sfl_pkg::sfl_cls_res_type     cls_res,
  input  wire logic                    age_update,
  output logic                         age_load_valid,
  output logic [sfl_pkg::AGE_W-1:0]    age_load_value,
  input  wire sfl_pkg::sfl_lkp_req_type lkp_req,
  output sfl_pkg::sfl_lkp_res_type     lkp_res,
  output logic                         vlan_mode_en,
  output logic                         rsvd_mc_en,
  output logic                         dbl_tag_en,
  output logic [sfl_pkg::TAG_W-1:0]    default_tag_type,
  output logic [sfl_pkg::LEN_W-1:0]    max_payload_length
);

  localparam int LEN_W = sfl_pkg::LEN_W;
  localparam int TAG_W = sfl_pkg::TAG_W;
  localparam int IDX_W = sfl_pkg::IDX_W;
  localparam int MAC_W = sfl_pkg::MAC_W;
  localparam int AGE_W = sfl_pkg::AGE_W;

  logic [LEN_W-1:0]     maxlen_reg;
  logic [LEN_W-1:0]     maxlen_next;
  logic [1:0]           spare_hi_reg;
  logic [1:0]           spare_hi_next;
  logic [TAG_W-1:0]     tag_reg;
  logic [TAG_W-1:0]     tag_next;
  logic                 dtag_reg;
  logic                 dtag_next;
  logic                 vlan_en_reg;
  logic                 vlan_en_next;
  logic                 drop_inv_reg;
  logic                 drop_inv_next;
  logic [AGE_W-1:0]     age_cnt_reg;
  logic [AGE_W-1:0]     age_cnt_next;
  logic                 rsvd_mc_reg;
  logic                 rsvd_mc_next;
  sfl_pkg::sfl_idx_type idx_reg;
  sfl_pkg::sfl_idx_type idx_next;
  logic [7:0]           rdata_reg;
  logic [7:0]           rdata_next;
  logic                 rvalid_reg;
  logic                 rvalid_next;

  // ********************************************
  // register writes and reads
  // ********************************************
  always_comb
  begin
    maxlen_next   = maxlen_reg;
    spare_hi_next = spare_hi_reg;
    tag_next      = tag_reg;
    dtag_next     = dtag_reg;
    vlan_en_next  = vlan_en_reg;
    drop_inv_next = drop_inv_reg;
    age_cnt_next  = age_cnt_reg;
    rsvd_mc_next  = rsvd_mc_reg;
    idx_next      = idx_reg;
    if (mgmt_req.wr)
    begin
      case (mgmt_req.addr)
        sfl_pkg::ADDR_SW_OP:
          dtag_next = mgmt_req.wdata[sfl_pkg::SWOP_DTAG_BIT];   // RULE_16
        sfl_pkg::ADDR_MAXLEN_HI:
          {spare_hi_next, maxlen_next[LEN_W-1:8]} = mgmt_req.wdata; // RULE_03
        sfl_pkg::ADDR_MAXLEN_LO:
          maxlen_next[7:0] = mgmt_req.wdata;                   // RULE_01
        sfl_pkg::ADDR_TAG_HI:
          tag_next[TAG_W-1:8] = mgmt_req.wdata;                // RULE_04
        sfl_pkg::ADDR_TAG_LO:
          tag_next[7:0] = mgmt_req.wdata;                      // RULE_04
        sfl_pkg::ADDR_LK0:
        begin
          vlan_en_next  = mgmt_req.wdata[sfl_pkg::LK0_VLAN_BIT];   // RULE_06
          drop_inv_next = mgmt_req.wdata[sfl_pkg::LK0_DROP_BIT];   // RULE_08
          age_cnt_next  = mgmt_req.wdata[sfl_pkg::LK0_AGE_LSB +: AGE_W]; // RULE_11
          rsvd_mc_next  = mgmt_req.wdata[sfl_pkg::LK0_RSVD_MC_BIT]; // RULE_13
          idx_next      = sfl_pkg::sfl_idx_type'(
                            mgmt_req.wdata[sfl_pkg::LK0_IDX_LSB +: 2]); // RULE_15
        end
        default:
          maxlen_next = maxlen_reg;
      endcase
    end
    rvalid_next = mgmt_req.rd;
    case (mgmt_req.addr)
      sfl_pkg::ADDR_SW_OP:
        rdata_next = {dtag_reg, 7'h00};
      sfl_pkg::ADDR_MAXLEN_HI:
        rdata_next = {spare_hi_reg, maxlen_reg[LEN_W-1:8]};
      sfl_pkg::ADDR_MAXLEN_LO:
        rdata_next = maxlen_reg[7:0];
      sfl_pkg::ADDR_TAG_HI:
        rdata_next = tag_reg[TAG_W-1:8];
      sfl_pkg::ADDR_TAG_LO:
        rdata_next = tag_reg[7:0];
      sfl_pkg::ADDR_LK0:
        rdata_next = {vlan_en_reg, drop_inv_reg, age_cnt_reg,
                      rsvd_mc_reg, idx_reg};
      default:
        rdata_next = 8'h00;
    endcase
    if (!mgmt_req.rd)
      rdata_next = rdata_reg;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      maxlen_reg   <= sfl_pkg::MAXLEN_RST;                     // RULE_01
      spare_hi_reg <= sfl_pkg::SPARE_HI_RST;
      tag_reg      <= sfl_pkg::TAG_RST;                        // RULE_04
      dtag_reg     <= sfl_pkg::DTAG_RST;
      vlan_en_reg  <= sfl_pkg::VLAN_RST;                       // RULE_06
      drop_inv_reg <= sfl_pkg::DROP_RST;                       // RULE_08
      age_cnt_reg  <= sfl_pkg::AGE_RST;                        // RULE_11
      rsvd_mc_reg  <= sfl_pkg::RSVD_MC_RST;                    // RULE_13
      idx_reg      <= sfl_pkg::IDX_CRC;                        // RULE_15
      rdata_reg    <= 8'h00;
      rvalid_reg   <= 1'h0;
    end
    else
    begin
      maxlen_reg   <= maxlen_next;
      spare_hi_reg <= spare_hi_next;
      tag_reg      <= tag_next;
      dtag_reg     <= dtag_next;
      vlan_en_reg  <= vlan_en_next;
      drop_inv_reg <= drop_inv_next;
      age_cnt_reg  <= age_cnt_next;
      rsvd_mc_reg  <= rsvd_mc_next;
      idx_reg      <= idx_next;
      rdata_reg    <= rdata_next;
      rvalid_reg   <= rvalid_next;
    end
  end

  // ********************************************
  // hash functions for table index
  // ********************************************
  function automatic logic [IDX_W-1:0] crc_index(
    input logic [MAC_W-1:0] mac
  );
    logic [IDX_W-1:0] c;
    logic             fb;
    c = '0;
    for (int i = MAC_W - 1; i >= 0; i--)
    begin
      fb = c[IDX_W-1] ^ mac[i];
      c  = {c[IDX_W-2:0], 1'h0};
      if (fb)
        c = c ^ sfl_pkg::CRC_POLY;
    end
    return c;
  endfunction

  function automatic logic [IDX_W-1:0] xor_index(
    input logic [MAC_W-1:0] mac
  );
    logic [IDX_W-1:0] c;
    c = '0;
    for (int i = 0; i < MAC_W; i++)
      c[i % IDX_W] = c[i % IDX_W] ^ mac[i];
    return c;
  endfunction

  // ********************************************
  // frame decisions, age load, table index
  // ********************************************
  sfl_pkg::sfl_cls_res_type cls_reg;
  sfl_pkg::sfl_cls_res_type cls_next;
  logic                     age_v_reg;
  logic                     age_v_next;
  logic [AGE_W-1:0]         age_val_reg;
  logic [AGE_W-1:0]         age_val_next;
  sfl_pkg::sfl_lkp_res_type lkp_reg;
  sfl_pkg::sfl_lkp_res_type lkp_next;

  always_comb
  begin
    cls_next            = '0;
    cls_next.valid      = cls_req.valid;
    cls_next.action     = sfl_pkg::ACT_FWD;                     // RULE_06
    if (vlan_en_reg && cls_req.vid_invalid)
    begin
      if (cls_req.unk_fwd_en)
        cls_next.action = sfl_pkg::ACT_UNK_VID;                // RULE_10
      else if (drop_inv_reg)
        cls_next.action = sfl_pkg::ACT_DROP;                   // RULE_08
      else
        cls_next.action = sfl_pkg::ACT_HOST;                   // RULE_09
    end
    if (cls_req.untagged)
      cls_next.inner_tpid = tag_reg;                           // RULE_04
    cls_next.push_outer = dtag_reg;                            // RULE_16
    if (dtag_reg)
      cls_next.outer_tpid = tag_reg;                           // RULE_05
    // only an update loads an age; stored ages are never rewritten
    age_v_next   = age_update;                                 // RULE_17
    age_val_next = age_update ? age_cnt_reg : age_val_reg;     // RULE_12
    lkp_next.valid = lkp_req.valid;
    case (idx_reg)
      sfl_pkg::IDX_CRC:
        lkp_next.index = crc_index(lkp_req.mac);               // RULE_15
      sfl_pkg::IDX_XOR:
        lkp_next.index = xor_index(lkp_req.mac);               // RULE_15
      default:
        lkp_next.index = lkp_req.mac[IDX_W-1:0];               // RULE_14
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cls_reg     <= '0;
      age_v_reg   <= 1'h0;
      age_val_reg <= '0;
      lkp_reg     <= '0;
    end
    else
    begin
      cls_reg     <= cls_next;
      age_v_reg   <= age_v_next;
      age_val_reg <= age_val_next;
      lkp_reg     <= lkp_next;
    end
  end

  sfl_frame_trunc #(
    .LEN_W     (LEN_W),
    .HDR_BYTES (sfl_pkg::HDR_BYTES)
  ) u_trunc (
    .clk         (clk),
    .nrst        (nrst),
    .max_len     (maxlen_reg),
    .in_beat     (frame_in),
    .out_beat    (frame_out),
    .trunc_pulse (frame_trunc)
  );

  assign mgmt_rdata         = rdata_reg;
  assign mgmt_rvalid        = rvalid_reg;
  assign cls_res            = cls_reg;
  assign age_load_valid     = age_v_reg;
  assign age_load_value     = age_val_reg;
  assign lkp_res            = lkp_reg;
  assign vlan_mode_en       = vlan_en_reg;
  assign rsvd_mc_en         = rsvd_mc_reg;
  assign dbl_tag_en         = dtag_reg;
  assign default_tag_type   = tag_reg;
  assign max_payload_length = maxlen_reg;

  // ********************************************
  // checks
  // ********************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence s_bad_vid;
    cls_req.valid && vlan_en_reg && cls_req.vid_invalid;
  endsequence

  a_reset_values: assert property ($past(!nrst) |-> // RULE_01
    maxlen_reg == sfl_pkg::MAXLEN_RST && tag_reg == sfl_pkg::TAG_RST &&
    {vlan_en_reg, drop_inv_reg, age_cnt_reg, rsvd_mc_reg, idx_reg}
      == 8'h61)
    else $error("reset value wrong");

  a_jumbo_limit: assert property (mgmt_req.wr && // RULE_03
    mgmt_req.addr == sfl_pkg::ADDR_MAXLEN_HI |=>
    maxlen_reg[LEN_W-1:8] == $past(mgmt_req.wdata[LEN_W-9:0]))
    else $error("payload limit not stored");

  a_outer_tag: assert property (cls_req.valid |=> cls_res.valid && // RULE_05
    cls_res.push_outer == $past(dtag_reg) &&
    (!$past(dtag_reg) || cls_res.outer_tpid == $past(tag_reg)))
    else $error("outer tag type wrong");

  a_vlan_off: assert property (cls_req.valid && !vlan_en_reg |=> // RULE_06
    cls_res.action == sfl_pkg::ACT_FWD)
    else $error("vlan filtering while disabled");

  a_invalid_drop: assert property (s_bad_vid and // RULE_08
    (!cls_req.unk_fwd_en && drop_inv_reg) |=>
    cls_res.action == sfl_pkg::ACT_DROP)
    else $error("invalid vid frame not dropped");

  a_invalid_host: assert property (s_bad_vid and // RULE_09
    (!cls_req.unk_fwd_en && !drop_inv_reg) |=>
    cls_res.action == sfl_pkg::ACT_HOST)
    else $error("invalid vid frame not sent to host");

  a_unk_override: assert property (s_bad_vid and cls_req.unk_fwd_en // RULE_10
    |=> cls_res.action == sfl_pkg::ACT_UNK_VID)
    else $error("unknown vid forwarding not preferred");

  a_age_load: assert property (age_update |=> age_load_valid && // RULE_12
    age_load_value == $past(age_cnt_reg))
    else $error("age count not loaded");

  a_age_hold: assert property (!age_update |=> !age_load_valid && // RULE_17
    $stable(age_load_value))
    else $error("age load without update");

  a_index_direct: assert property (lkp_req.valid && // RULE_14
    (idx_reg == sfl_pkg::IDX_DIRECT || idx_reg == sfl_pkg::IDX_DIRECT_ALT)
    |=> lkp_res.valid && lkp_res.index == $past(lkp_req.mac[IDX_W-1:0]))
    else $error("direct index wrong");

endmodule // sfl_cfg_top

// file: verification/tb_sfl_cfg_top.sv
/*
 * Self-checking bench for the frame and lookup configuration block:
 * register reset values and access, classify, age load, lookup index
 * and payload cut.
 * Assumes sfl_pkg and the design files under src/ are compiled first.
 */
`timescale 1ns/1ps
module tb_sfl_cfg_top;
  logic                      clk;
  logic                      nrst;
  sfl_pkg::sfl_mgmt_req_type mreq;
  logic [7:0]                rdata;
  logic                      rvalid;
  sfl_pkg::sfl_beat_type     fin;
  sfl_pkg::sfl_beat_type     fout;
  logic                      ftrunc;
  sfl_pkg::sfl_cls_req_type  creq;
  sfl_pkg::sfl_cls_res_type  cres;
  logic                      age_upd;
  logic                      age_vld;
  logic [2:0]                age_val;
  sfl_pkg::sfl_lkp_req_type  lreq;
  sfl_pkg::sfl_lkp_res_type  lres;
  logic                      vlan_en;
  logic                      rmc_en;
  logic                      dtag_en;
  logic [15:0]               tag;
  logic [13:0]               maxl;
  int                        err_total;
  int                        checks;

  sfl_cfg_top u_dut (
    .clk                (clk),
    .nrst               (nrst),
    .mgmt_req           (mreq),
    .mgmt_rdata         (rdata),
    .mgmt_rvalid        (rvalid),
    .frame_in           (fin),
    .frame_out          (fout),
    .frame_trunc        (ftrunc),
    .cls_req            (creq),
    .cls_res            (cres),
    .age_update         (age_upd),
    .age_load_valid     (age_vld),
    .age_load_value     (age_val),
    .lkp_req            (lreq),
    .lkp_res            (lres),
    .vlan_mode_en       (vlan_en),
    .rsvd_mc_en         (rmc_en),
    .dbl_tag_en         (dtag_en),
    .default_tag_type   (tag),
    .max_payload_length (maxl)
  );

  always #5 clk = ~clk;

  // ********************************************
  // checking and closing
  // ********************************************
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    checks++;
    if (g !== e)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ********************************************
  // port transactions
  // ********************************************
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    mreq = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    mreq = '0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(negedge clk);
    mreq = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    mreq = '0;
    chk("rvalid", 16'h0001, 16'(rvalid));
    chk("rdata", 16'(e), 16'(rdata));
  endtask

  task automatic cls(input logic u, input logic v, input logic k,
                     input logic [1:0] act, input logic [15:0] it,
                     input logic po, input logic [15:0] ot);
    @(negedge clk);
    creq = '{1'b1, u, v, k};
    @(negedge clk);
    creq = '0;
    chk("cls valid", 16'h0001, 16'(cres.valid));
    chk("action", 16'(act), 16'(cres.action));
    chk("inner tag", it, cres.inner_tpid);
    chk("push outer", 16'(po), 16'(cres.push_outer));
    chk("outer tag", ot, cres.outer_tpid);
  endtask

  task automatic lk(input logic [47:0] m, input logic [9:0] e);
    @(negedge clk);
    lreq = '{1'b1, m};
    @(negedge clk);
    lreq = '0;
    chk("lkp valid", 16'h0001, 16'(lres.valid));
    chk("index", 16'(e), 16'(lres.index));
  endtask

  task automatic frame(input int len, input int ecnt, input logic etr);
    int         n;
    logic [7:0] ld;
    logic       tr;
    n  = 0;
    ld = 8'h00;
    tr = 1'b0;
    for (int i = 1; i <= len + 2; i++)
    begin
      @(negedge clk);
      if (fout.valid === 1'b1)
      begin
        n++;
        ld = fout.data;
        tr = fout.eop & ftrunc;
      end
      if (i <= len)
        fin = '{1'b1, i == 1, i == len, 8'(i)};
      else
        fin = '0;
    end
    chk("beats", 16'(ecnt), 16'(n));
    chk("last byte", 16'(ecnt), 16'(ld));
    chk("cut", 16'(etr), 16'(tr));
  endtask

  // hash references
  function automatic logic [9:0] crc10(input logic [47:0] m);
    logic [9:0] c;
    c = 10'h000;
    for (int i = 47; i >= 0; i--)
      c = {c[8:0], 1'b0} ^ ((c[9] ^ m[i]) ? sfl_pkg::CRC_POLY : 10'h000);
    return c;
  endfunction

  function automatic logic [9:0] xr10(input logic [47:0] m);
    logic [9:0] x;
    x = 10'h000;
    for (int i = 0; i < 48; i++)
      x[i % 10] ^= m[i];
    return x;
  endfunction

  // ********************************************
  // main sequence
  // ********************************************
  initial
  begin
    clk = 1'b0;
    nrst = 1'b0;
    mreq = '0;
    fin = '0;
    creq = '0;
    age_upd = 1'b0;
    lreq = '0;
    err_total = 0;
    checks = 0;
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    rd(16'h0308, 8'h07);
    rd(16'h0309, 8'hD0);
    rd(16'h030A, 8'h91);
    rd(16'h030B, 8'h00);
    rd(16'h0310, 8'h61);
    rd(16'h0300, 8'h00);
    rd(16'h03FF, 8'h00);
    wr(16'h0308, 8'hE3);
    wr(16'h0309, 8'h28);
    rd(16'h0308, 8'hE3);
    chk("max len", 16'h2328, 16'(maxl));
    wr(16'h030A, 8'h88);
    wr(16'h030B, 8'hA8);
    chk("tag", 16'h88A8, tag);
    cls(1'b1, 1'b1, 1'b0, 2'h0, 16'h88A8, 1'b0, 16'h0000);
    wr(16'h0310, 8'hE1);
    chk("vlan en", 16'h0001, 16'(vlan_en));
    cls(1'b1, 1'b1, 1'b0, 2'h1, 16'h88A8, 1'b0, 16'h0000);
    cls(1'b0, 1'b0, 1'b0, 2'h0, 16'h0000, 1'b0, 16'h0000);
    cls(1'b0, 1'b1, 1'b1, 2'h3, 16'h0000, 1'b0, 16'h0000);
    wr(16'h0310, 8'hA1);
    cls(1'b0, 1'b1, 1'b0, 2'h2, 16'h0000, 1'b0, 16'h0000);
    cls(1'b0, 1'b1, 1'b1, 2'h3, 16'h0000, 1'b0, 16'h0000);
    wr(16'h0300, 8'h80);
    rd(16'h0300, 8'h80);
    chk("dtag en", 16'h0001, 16'(dtag_en));
    cls(1'b1, 1'b0, 1'b0, 2'h0, 16'h88A8, 1'b1, 16'h88A8);
    wr(16'h0310, 8'h94);
    rd(16'h0310, 8'h94);
    chk("rsvd mc", 16'h0001, 16'(rmc_en));
    @(negedge clk);
    age_upd = 1'b1;
    @(negedge clk);
    age_upd = 1'b0;
    chk("age valid", 16'h0001, 16'(age_vld));
    chk("age value", 16'h0002, 16'(age_val));
    lk(48'h0123_4567_89AB, 10'h1AB);
    wr(16'h0310, 8'h97);
    lk(48'hFEDC_BA98_7654, 10'h254);
    wr(16'h0310, 8'h95);
    lk(48'h0123_4567_89AB, crc10(48'h0123_4567_89AB));
    wr(16'h0310, 8'h96);
    lk(48'h0123_4567_89AB, xr10(48'h0123_4567_89AB));
    wr(16'h0308, 8'h00);
    wr(16'h0309, 8'h02);
    frame(20, 16, 1'b1);
    frame(16, 16, 1'b0);
    frame(5, 5, 1'b0);
    give_verdict();
  end

  // hang guard
  initial
  begin
    #500000;
    err_total++;
    give_verdict();
  end
endmodule // tb_sfl_cfg_top
